// ==== hw/csfx_defs.svh ====
`ifndef CSFX_DEFS_SVH
`define CSFX_DEFS_SVH

// ------
// Status flag bit positions
// ------
`define CSFX_FLAG_C 3'd0
`define CSFX_FLAG_Z 3'd1
`define CSFX_FLAG_N 3'd2
`define CSFX_FLAG_V 3'd3
`define CSFX_FLAG_S 3'd4
`define CSFX_FLAG_H 3'd5
`define CSFX_FLAG_T 3'd6
`define CSFX_FLAG_I 3'd7

// ------
// Register file layout
// ------
`define CSFX_NUM_REGS 32
`define CSFX_PTR_BASE 5'h1a
`define CSFX_HI_BIT 5'h01
`define CSFX_R0_IDX 5'h00

// ------
// Reset values and constants
// ------
`define CSFX_REG_RESET 8'h00
`define CSFX_FLAGS_RESET 8'h00
`define CSFX_SP_RESET 16'h0000
`define CSFX_ONE16 16'h0001

`endif

// ==== hw/csfx_pkg.sv ====
`include "csfx_defs.svh"

package csfx_pkg;

  // ------
  // Operations and addressing
  // ------
  typedef enum logic [4:0] {
    no_op = 5'h00,
    rotate_right_carry_op = 5'h01,
    arith_shift_right_op = 5'h02,
    bit_store_to_flag_op = 5'h03,
    bit_load_from_flag_op = 5'h04,
    generic_flag_set_op = 5'h05,
    generic_flag_clear_op = 5'h06,
    indirect_load_op = 5'h07,
    displaced_load_op = 5'h08,
    indirect_store_op = 5'h09,
    displaced_store_op = 5'h0a,
    direct_data_load_op = 5'h0b,
    direct_data_store_op = 5'h0c,
    program_memory_read_op = 5'h0d,
    stack_push_op = 5'h0e,
    stack_pop_op = 5'h0f,
    debug_break_op = 5'h10
  } csfx_op_t;

  typedef enum logic [1:0] {
    am_plain = 2'b00,
    am_post_inc = 2'b01,
    am_pre_dec = 2'b10
  } csfx_amode_t;

  typedef enum logic [1:0] {
    ptr_x = 2'b00,
    ptr_y = 2'b01,
    ptr_z = 2'b10
  } csfx_ptr_t;

  typedef enum logic [2:0] {
    s_idle = 3'b000,
    s_data = 3'b001,
    s_pwait = 3'b010,
    s_pread = 3'b011,
    s_debug = 3'b100
  } csfx_state_t;

  // ------
  // Carriers
  // ------
  typedef struct packed {
    csfx_op_t op;
    csfx_amode_t amode;
    csfx_ptr_t ptr;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bit_sel;
    logic [5:0] disp;
    logic [15:0] addr;
    logic pgm_to_r0;
  } csfx_op_req_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } csfx_dmem_req_t;

  // ------
  // Shared decoders
  // ------
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  function automatic logic [4:0] ptr_lo_idx(input csfx_ptr_t sel);
    ptr_lo_idx = `CSFX_PTR_BASE + {2'b00, sel, 1'b0};
  endfunction

endpackage

// ==== hw/csfx_regfile.sv ====
`timescale 1ns/1ns
`include "csfx_defs.svh"

module csfx_regfile (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Read ports
  input wire logic [4:0] rd_a_idx,
  output logic [7:0] rd_a_data,
  input wire logic [4:0] rd_b_idx,
  output logic [7:0] rd_b_data,
  input wire logic [4:0] rd_c_idx,
  output logic [7:0] rd_c_data,
  // Byte write port
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Pointer pair write port
  input wire logic pw_en,
  input wire csfx_pkg::csfx_ptr_t pw_sel,
  input wire logic [15:0] pw_data,
  // Pointer pair values
  output logic [15:0] ptr_x_val,
  output logic [15:0] ptr_y_val,
  output logic [15:0] ptr_z_val
);

  logic [7:0] regs_q [`CSFX_NUM_REGS];
  logic [7:0] regs_d [`CSFX_NUM_REGS];
  logic [4:0] lo_idx;
  logic [4:0] hi_idx;

  assign lo_idx = csfx_pkg::ptr_lo_idx(pw_sel);
  assign hi_idx = lo_idx | `CSFX_HI_BIT;

  // ------
  // Storage
  // ------
  // Byte write wins over a pointer write
  for (genvar i = 0; i < `CSFX_NUM_REGS; i++) begin : g_reg
    always_comb begin
      regs_d[i] = regs_q[i];
      if (pw_en && lo_idx == 5'(i)) begin
        regs_d[i] = pw_data[7:0];
      end
      if (pw_en && hi_idx == 5'(i)) begin
        regs_d[i] = pw_data[15:8];
      end
      if (wr_en && wr_idx == 5'(i)) begin
        regs_d[i] = wr_data;
      end
    end

    always_ff @(posedge core_clk) begin
      if (reset) begin
        regs_q[i] <= `CSFX_REG_RESET;
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  assign rd_a_data = regs_q[rd_a_idx];
  assign rd_b_data = regs_q[rd_b_idx];
  assign rd_c_data = regs_q[rd_c_idx];
  assign ptr_x_val = {regs_q[csfx_pkg::ptr_lo_idx(csfx_pkg::ptr_x) | `CSFX_HI_BIT],
                      regs_q[csfx_pkg::ptr_lo_idx(csfx_pkg::ptr_x)]};
  assign ptr_y_val = {regs_q[csfx_pkg::ptr_lo_idx(csfx_pkg::ptr_y) | `CSFX_HI_BIT],
                      regs_q[csfx_pkg::ptr_lo_idx(csfx_pkg::ptr_y)]};
  assign ptr_z_val = {regs_q[csfx_pkg::ptr_lo_idx(csfx_pkg::ptr_z) | `CSFX_HI_BIT],
                      regs_q[csfx_pkg::ptr_lo_idx(csfx_pkg::ptr_z)]};

endmodule // csfx_regfile

// ==== hw/csfx_shift_flag_unit.sv ====
`timescale 1ns/1ns
`include "csfx_defs.svh"

module csfx_shift_flag_unit (
  // Operation
  input wire csfx_pkg::csfx_op_t op,
  input wire logic [2:0] bit_sel,
  // Operands
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] flags_in,
  // Results
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic [7:0] mask;
  logic shift_c;
  logic is_shift;

  assign mask = csfx_pkg::bit_mask(bit_sel);

  always_comb begin
    result = rd_val;
    flags_out = flags_in;
    shift_c = rd_val[0];
    is_shift = 1'b0;
    case (op)
      csfx_pkg::rotate_right_carry_op: begin
        result = {flags_in[`CSFX_FLAG_C], rd_val[7:1]}; // RULE1
        is_shift = 1'b1;
      end
      csfx_pkg::arith_shift_right_op: begin
        result = {rd_val[7], rd_val[7:1]}; // RULE1
        is_shift = 1'b1;
      end
      csfx_pkg::bit_store_to_flag_op: begin
        flags_out[`CSFX_FLAG_T] = |(rr_val & mask); // RULE2
      end
      csfx_pkg::bit_load_from_flag_op: begin
        result = flags_in[`CSFX_FLAG_T] ? (rd_val | mask) : (rd_val & ~mask); // RULE3
      end
      csfx_pkg::generic_flag_set_op: begin
        flags_out = flags_in | mask; // RULE4
      end
      csfx_pkg::generic_flag_clear_op: begin
        flags_out = flags_in & ~mask; // RULE4
      end
      default: begin
        result = rd_val;
      end
    endcase
    if (is_shift) begin
      flags_out[`CSFX_FLAG_C] = shift_c; // RULE1
      flags_out[`CSFX_FLAG_Z] = (result == 8'h00); // RULE16
      flags_out[`CSFX_FLAG_N] = result[7]; // RULE16
      flags_out[`CSFX_FLAG_V] = result[7] ^ shift_c; // RULE16
    end
  end

endmodule // csfx_shift_flag_unit

// ==== hw/csfx_exec.sv ====
`timescale 1ns/1ns
`include "csfx_defs.svh"

// Contract
// RULE1: Rotate through carry and arithmetic shift right take one cycle.
// RULE2: Bit store copies one source bit into the transfer flag only.
// RULE3: Bit load writes the transfer flag into one bit; flags kept.
// RULE4: Flag set or clear forces only its own bit in one cycle.
// RULE5: Indirect loads take two cycles; post-increment reads then bumps pointer.
// RULE6: Pre-decrement load lowers pointer first, then reads at new value.
// RULE7: Displaced load uses second or third pair plus offset, pointer kept.
// RULE8: Indirect stores take two cycles with post-increment and pre-decrement forms.
// RULE9: Displaced store writes at second or third pair plus offset, pointer kept.
// RULE10: Direct load reads immediate address into destination in two cycles.
// RULE11: Direct store writes source to immediate address in two cycles.
// RULE12: Program memory read via third pair takes three cycles, optional post-increment.
// RULE13: Push writes source onto stack in two cycles, flags untouched.
// RULE14: Pop loads destination from stack in two cycles, flags untouched.
// RULE15: Break halts for the debugger only; no count, flags kept.
// RULE16: Shifts set zero, negative from bit seven, overflow N xor C.

module csfx_exec (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Decoded operation
  input wire logic op_valid,
  input wire csfx_pkg::csfx_op_req_t op_req,
  output logic op_ready,
  output logic op_done,
  // Data memory
  output csfx_pkg::csfx_dmem_req_t dmem_req,
  input wire logic [7:0] dmem_rdata,
  // Program memory
  output logic pmem_re,
  output logic [14:0] pmem_addr,
  input wire logic [15:0] pmem_rdata,
  // Debug
  output logic debug_halt,
  input wire logic debug_resume,
  input wire logic [4:0] dbg_reg_idx,
  output logic [7:0] dbg_reg_data,
  // State view
  output logic [7:0] status_flag_register,
  output logic [15:0] stack_ptr
);

  // ------
  // State
  // ------
  csfx_pkg::csfx_state_t state_q, state_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] sp_q, sp_d;
  csfx_pkg::csfx_dmem_req_t dmem_q, dmem_d;
  logic pmem_re_q, pmem_re_d;
  logic [14:0] pmem_addr_q, pmem_addr_d;
  logic wb_en_q, wb_en_d;
  logic [4:0] wb_idx_q, wb_idx_d;
  logic zhi_q, zhi_d;
  logic done_q, done_d;

  // ------
  // Register file and shift unit wiring
  // ------
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [7:0] wr_data;
  logic pw_en;
  csfx_pkg::csfx_ptr_t pw_sel;
  logic [15:0] pw_data;
  logic [15:0] ptr_x_val;
  logic [15:0] ptr_y_val;
  logic [15:0] ptr_z_val;
  logic [7:0] alu_result;
  logic [7:0] alu_flags;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] disp_addr;
  logic take;

  csfx_regfile u_regfile (
    .core_clk(core_clk),
    .reset(reset),
    .rd_a_idx(op_req.rd),
    .rd_a_data(rd_val),
    .rd_b_idx(op_req.rr),
    .rd_b_data(rr_val),
    .rd_c_idx(dbg_reg_idx),
    .rd_c_data(dbg_reg_data),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .pw_en(pw_en),
    .pw_sel(pw_sel),
    .pw_data(pw_data),
    .ptr_x_val(ptr_x_val),
    .ptr_y_val(ptr_y_val),
    .ptr_z_val(ptr_z_val)
  );

  csfx_shift_flag_unit u_shift_flag (
    .op(op_req.op),
    .bit_sel(op_req.bit_sel),
    .rd_val(rd_val),
    .rr_val(rr_val),
    .flags_in(flags_q),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  // ------
  // Address arithmetic
  // ------
  always_comb begin
    case (op_req.ptr)
      csfx_pkg::ptr_y: ptr_cur = ptr_y_val;
      csfx_pkg::ptr_z: ptr_cur = ptr_z_val;
      default: ptr_cur = ptr_x_val;
    endcase
  end

  assign ptr_inc = ptr_cur + `CSFX_ONE16;
  assign ptr_dec = ptr_cur - `CSFX_ONE16;
  // No offset form exists for the first pair, so its offset is ignored
  assign disp_addr = (op_req.ptr == csfx_pkg::ptr_x) ? ptr_cur : (ptr_cur + {10'h000, op_req.disp}); // RULE7 RULE9
  assign take = op_valid && (state_q == csfx_pkg::s_idle);

  // ------
  // Next state
  // ------
  always_comb begin
    state_d = state_q;
    flags_d = flags_q;
    sp_d = sp_q;
    dmem_d = '0;
    pmem_re_d = 1'b0;
    pmem_addr_d = pmem_addr_q;
    wb_en_d = wb_en_q;
    wb_idx_d = wb_idx_q;
    zhi_d = zhi_q;
    done_d = 1'b0;
    wr_en = 1'b0;
    wr_idx = op_req.rd;
    wr_data = alu_result;
    pw_en = 1'b0;
    pw_sel = op_req.ptr;
    pw_data = ptr_inc;
    case (state_q)
      csfx_pkg::s_idle: begin
        if (take) begin
          wb_en_d = 1'b0;
          wb_idx_d = op_req.rd;
          case (op_req.op)
            csfx_pkg::rotate_right_carry_op, csfx_pkg::arith_shift_right_op: begin
              wr_en = 1'b1; // RULE1
              flags_d = alu_flags; // RULE1 RULE16
              done_d = 1'b1;
            end
            csfx_pkg::bit_store_to_flag_op, csfx_pkg::generic_flag_set_op,
            csfx_pkg::generic_flag_clear_op: begin
              flags_d = alu_flags; // RULE2 RULE4
              done_d = 1'b1;
            end
            csfx_pkg::bit_load_from_flag_op: begin
              wr_en = 1'b1; // RULE3
              done_d = 1'b1;
            end
            csfx_pkg::indirect_load_op, csfx_pkg::indirect_store_op: begin
              dmem_d.re = (op_req.op == csfx_pkg::indirect_load_op); // RULE5
              dmem_d.we = (op_req.op == csfx_pkg::indirect_store_op); // RULE8
              dmem_d.wdata = rr_val;
              dmem_d.addr = (op_req.amode == csfx_pkg::am_pre_dec) ? ptr_dec : ptr_cur; // RULE6 RULE8
              pw_en = (op_req.amode != csfx_pkg::am_plain); // RULE5 RULE8
              pw_data = (op_req.amode == csfx_pkg::am_pre_dec) ? ptr_dec : ptr_inc; // RULE6
              wb_en_d = (op_req.op == csfx_pkg::indirect_load_op);
              state_d = csfx_pkg::s_data;
            end
            csfx_pkg::displaced_load_op, csfx_pkg::displaced_store_op: begin
              dmem_d.re = (op_req.op == csfx_pkg::displaced_load_op); // RULE7
              dmem_d.we = (op_req.op == csfx_pkg::displaced_store_op); // RULE9
              dmem_d.wdata = rr_val;
              dmem_d.addr = disp_addr;
              wb_en_d = (op_req.op == csfx_pkg::displaced_load_op);
              state_d = csfx_pkg::s_data;
            end
            csfx_pkg::direct_data_load_op, csfx_pkg::direct_data_store_op: begin
              dmem_d.re = (op_req.op == csfx_pkg::direct_data_load_op); // RULE10
              dmem_d.we = (op_req.op == csfx_pkg::direct_data_store_op); // RULE11
              dmem_d.wdata = rr_val;
              dmem_d.addr = op_req.addr; // RULE10 RULE11
              wb_en_d = (op_req.op == csfx_pkg::direct_data_load_op);
              state_d = csfx_pkg::s_data;
            end
            csfx_pkg::program_memory_read_op: begin
              pmem_re_d = 1'b1; // RULE12
              pmem_addr_d = ptr_z_val[15:1];
              zhi_d = ptr_z_val[0];
              wb_idx_d = op_req.pgm_to_r0 ? `CSFX_R0_IDX : op_req.rd; // RULE12
              pw_sel = csfx_pkg::ptr_z;
              pw_data = ptr_z_val + `CSFX_ONE16;
              pw_en = (op_req.amode == csfx_pkg::am_post_inc); // RULE12
              wb_en_d = 1'b1;
              state_d = csfx_pkg::s_pwait;
            end
            csfx_pkg::stack_push_op: begin
              dmem_d.we = 1'b1; // RULE13
              dmem_d.addr = sp_q;
              dmem_d.wdata = rr_val;
              sp_d = sp_q - `CSFX_ONE16; // RULE13
              state_d = csfx_pkg::s_data;
            end
            csfx_pkg::stack_pop_op: begin
              dmem_d.re = 1'b1; // RULE14
              dmem_d.addr = sp_q + `CSFX_ONE16;
              sp_d = sp_q + `CSFX_ONE16; // RULE14
              wb_en_d = 1'b1;
              state_d = csfx_pkg::s_data;
            end
            csfx_pkg::debug_break_op: begin
              state_d = csfx_pkg::s_debug; // RULE15
            end
            default: begin
              done_d = 1'b1;
            end
          endcase
        end
      end
      csfx_pkg::s_data: begin
        // Memory answers in the cycle its strobe is high
        wr_en = wb_en_q; // RULE5 RULE10 RULE14
        wr_idx = wb_idx_q;
        wr_data = dmem_rdata;
        done_d = 1'b1;
        state_d = csfx_pkg::s_idle;
      end
      csfx_pkg::s_pwait: begin
        state_d = csfx_pkg::s_pread; // RULE12
      end
      csfx_pkg::s_pread: begin
        wr_en = 1'b1; // RULE12
        wr_idx = wb_idx_q;
        wr_data = zhi_q ? pmem_rdata[15:8] : pmem_rdata[7:0];
        done_d = 1'b1;
        state_d = csfx_pkg::s_idle;
      end
      csfx_pkg::s_debug: begin
        // Halted until the debugger lets go; flags stay as they were
        if (debug_resume) begin
          done_d = 1'b1; // RULE15
          state_d = csfx_pkg::s_idle;
        end
      end
      default: begin
        state_d = csfx_pkg::s_idle;
      end
    endcase
  end

  // ------
  // Registers
  // ------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= csfx_pkg::s_idle;
      flags_q <= `CSFX_FLAGS_RESET;
      sp_q <= `CSFX_SP_RESET;
      dmem_q <= '0;
      pmem_re_q <= 1'b0;
      pmem_addr_q <= '0;
      wb_en_q <= 1'b0;
      wb_idx_q <= '0;
      zhi_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      flags_q <= flags_d;
      sp_q <= sp_d;
      dmem_q <= dmem_d;
      pmem_re_q <= pmem_re_d;
      pmem_addr_q <= pmem_addr_d;
      wb_en_q <= wb_en_d;
      wb_idx_q <= wb_idx_d;
      zhi_q <= zhi_d;
      done_q <= done_d;
    end
  end

  // ------
  // Outputs
  // ------
  assign op_ready = (state_q == csfx_pkg::s_idle);
  assign op_done = done_q;
  assign dmem_req = dmem_q;
  assign pmem_re = pmem_re_q;
  assign pmem_addr = pmem_addr_q;
  assign debug_halt = (state_q == csfx_pkg::s_debug);
  assign status_flag_register = flags_q;
  assign stack_ptr = sp_q;

endmodule // csfx_exec

// ==== verif/csfx_exec_checker.sv ====
`timescale 1ns/1ns

module csfx_exec_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Operation handshake
  input wire logic op_valid,
  input wire csfx_pkg::csfx_op_req_t op_req,
  input wire logic op_ready,
  input wire logic op_done,
  // Memories
  input wire csfx_pkg::csfx_dmem_req_t dmem_req,
  input wire logic pmem_re,
  // State view
  input wire logic debug_halt,
  input wire logic [7:0] status_flag_register,
  input wire logic [15:0] stack_ptr
);
  // ------
  // Accepted request decode
  // ------
  logic take;
  logic shift_op;
  logic mem_op;
  assign take = op_valid && op_ready;
  assign shift_op = op_req.op inside {csfx_pkg::rotate_right_carry_op, csfx_pkg::arith_shift_right_op};
  assign mem_op = op_req.op inside {[csfx_pkg::indirect_load_op:csfx_pkg::direct_data_store_op],
    csfx_pkg::stack_push_op, csfx_pkg::stack_pop_op};

  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ------
  // Properties
  // ------
  chk_shift_done:
    assert property (take && shift_op |-> ##1 op_done) else $error("shift not done in one cycle");
  chk_shift_ovf:
    assert property (take && shift_op |=> status_flag_register[3] == (status_flag_register[2] ^ status_flag_register[0])
      && status_flag_register[7:5] == $past(status_flag_register[7:5])) else $error("shift flags wrong");
  chk_tstore_only:
    assert property (take && op_req.op == csfx_pkg::bit_store_to_flag_op
      |=> ((status_flag_register ^ $past(status_flag_register)) & 8'hbf) == 8'h00) else $error("bit store hit flags");
  chk_tload_flags:
    assert property (take && op_req.op == csfx_pkg::bit_load_from_flag_op |=> $stable(status_flag_register))
      else $error("bit load changed flags");
  chk_flag_set:
    assert property (take && op_req.op == csfx_pkg::generic_flag_set_op
      |=> status_flag_register == ($past(status_flag_register) | (8'h01 << $past(op_req.bit_sel))))
      else $error("flag set wrong");
  chk_flag_clear:
    assert property (take && op_req.op == csfx_pkg::generic_flag_clear_op
      |=> status_flag_register == ($past(status_flag_register) & ~(8'h01 << $past(op_req.bit_sel))))
      else $error("flag clear wrong");
  chk_mem_two:
    assert property (take && mem_op |-> ##1 (dmem_req.re ^ dmem_req.we) && !op_ready ##1 op_done && op_ready)
      else $error("memory op not two cycles");
  chk_mem_flags:
    assert property (take && mem_op |=> $stable(status_flag_register) [*2]) else $error("memory op changed flags");
  chk_pgm_three:
    assert property (take && op_req.op == csfx_pkg::program_memory_read_op
      |-> ##1 pmem_re && !op_ready ##1 !op_ready ##1 op_done) else $error("program read not three cycles");
  chk_push_sp:
    assert property (take && op_req.op == csfx_pkg::stack_push_op |=> dmem_req.we
      && dmem_req.addr == $past(stack_ptr) && stack_ptr == $past(stack_ptr) - 16'h0001) else $error("push wrong");
  chk_pop_sp:
    assert property (take && op_req.op == csfx_pkg::stack_pop_op |=> dmem_req.re
      && stack_ptr == $past(stack_ptr) + 16'h0001 && dmem_req.addr == stack_ptr) else $error("pop wrong");
  chk_break_halt:
    assert property (take && op_req.op == csfx_pkg::debug_break_op |=> debug_halt && $stable(status_flag_register))
      else $error("break did not halt");

  cover property (take && op_req.op == csfx_pkg::stack_push_op);
  cover property (take && op_req.op == csfx_pkg::program_memory_read_op);
  cover property (take && op_req.op == csfx_pkg::debug_break_op);
endmodule // csfx_exec_checker

bind csfx_exec csfx_exec_checker csfx_exec_checker_i (.core_clk, .reset, .op_valid, .op_req, .op_ready, .op_done,
  .dmem_req, .pmem_re, .debug_halt, .status_flag_register, .stack_ptr);

// ==== verif/csfx_mem_model.sv ====
`timescale 1ns/1ns

module csfx_mem_model (
  // Clock
  input wire logic core_clk,
  // Data memory
  input wire csfx_pkg::csfx_dmem_req_t dmem_req,
  output logic [7:0] dmem_rdata,
  // Program memory
  input wire logic pmem_re,
  input wire logic [14:0] pmem_addr,
  output logic [15:0] pmem_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q = 8'h00;
  logic [15:0] word_q = 16'h0000;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // Idle bus shows the inverse of the last byte
  assign dmem_rdata = dmem_req.re ? mem[dmem_req.addr[7:0]] : ~last_q;
  // Word one cycle after the strobe, garbage otherwise
  assign pmem_rdata = word_q;

  always @(posedge core_clk) begin
    if (dmem_req.re) begin
      last_q <= mem[dmem_req.addr[7:0]];
    end
    if (dmem_req.we) begin
      mem[dmem_req.addr[7:0]] <= dmem_req.wdata;
    end
    word_q <= pmem_re ? {pmem_addr[7:0] ^ 8'ha5, pmem_addr[7:0]} : ~word_q;
  end
endmodule // csfx_mem_model

// ==== verif/test_cpu_shift_flag_transfer_exec.sv ====
`timescale 1ns/1ns
`define CSFX_CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end

module test_cpu_shift_flag_transfer_exec;
  // ------
  // Signals
  // ------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  logic debug_resume = 1'b0;
  logic [4:0] dbg_reg_idx = 5'h00;
  csfx_pkg::csfx_op_req_t op_req = '0;
  csfx_pkg::csfx_op_req_t rq = '0;
  csfx_pkg::csfx_dmem_req_t dmem_req;
  logic op_ready, op_done, pmem_re, debug_halt;
  logic [7:0] dmem_rdata, dbg_reg_data, status_flag_register, fl;
  logic [14:0] pmem_addr;
  logic [15:0] pmem_rdata, stack_ptr;
  int fail_count = 0;
  int n_compared = 0;

  csfx_exec csfx_exec_i (.core_clk, .reset, .op_valid, .op_req, .op_ready, .op_done, .dmem_req, .dmem_rdata,
    .pmem_re, .pmem_addr, .pmem_rdata, .debug_halt, .debug_resume, .dbg_reg_idx, .dbg_reg_data,
    .status_flag_register, .stack_ptr);
  csfx_mem_model csfx_mem_model_i (.core_clk, .dmem_req, .dmem_rdata, .pmem_re, .pmem_addr, .pmem_rdata);

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // ------
  // Shared tasks
  // ------
  task automatic go(input csfx_pkg::csfx_op_t op, input logic [4:0] r, input logic [2:0] b, input int cyc);
    int n;
    n = 0;
    rq.op = op;
    rq.rd = r;
    rq.rr = r;
    rq.bit_sel = b;
    @(posedge core_clk);
    #1;
    op_req = rq;
    op_valid = 1'b1;
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    while (op_done !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CSFX_CHECK(n + 1, cyc)
  endtask

  task automatic chk(input logic [4:0] idx, input logic [7:0] e);
    @(posedge core_clk);
    #1;
    dbg_reg_idx = idx;
    #1;
    `CSFX_CHECK(dbg_reg_data, e)
  endtask

  // Registers load through a spare memory byte
  task automatic setreg(input logic [4:0] idx, input logic [7:0] v);
    csfx_mem_model_i.mem[8'hf0] = v;
    rq.addr = 16'h00f0;
    go(csfx_pkg::direct_data_load_op, idx, 3'h0, 2);
    chk(idx, v);
    `CSFX_CHECK(status_flag_register, fl)
  endtask

  task automatic done(input string s);
    $display("%s finished, %0d compared, %0d failed", s, n_compared, fail_count);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      go(csfx_pkg::generic_flag_clear_op, 5'h00, 3'(i), 1);
    end
    fl = 8'h00;
    `CSFX_CHECK(status_flag_register, fl)
    for (int i = 0; i < 8; i++) begin
      go(csfx_pkg::generic_flag_set_op, 5'h00, 3'(i), 1);
      fl = fl | (8'h01 << i);
      `CSFX_CHECK(status_flag_register, fl)
    end
    for (int i = 0; i < 8; i++) begin
      go(csfx_pkg::generic_flag_clear_op, 5'h00, 3'(i), 1);
      fl = fl & ~(8'h01 << i);
      `CSFX_CHECK(status_flag_register, fl)
    end
    done("flags");
  endtask

  task automatic t_shift_bits();
    setreg(5'h10, 8'h81);
    go(csfx_pkg::generic_flag_set_op, 5'h00, 3'h0, 1);
    go(csfx_pkg::rotate_right_carry_op, 5'h10, 3'h0, 1);
    chk(5'h10, 8'hc0);
    `CSFX_CHECK(status_flag_register, 8'h05)
    go(csfx_pkg::arith_shift_right_op, 5'h10, 3'h0, 1);
    chk(5'h10, 8'he0);
    `CSFX_CHECK(status_flag_register, 8'h0c)
    fl = 8'h0c;
    setreg(5'h10, 8'h01);
    go(csfx_pkg::arith_shift_right_op, 5'h10, 3'h0, 1);
    chk(5'h10, 8'h00);
    `CSFX_CHECK(status_flag_register, 8'h0b)
    fl = 8'h0b;
    setreg(5'h05, 8'h20);
    go(csfx_pkg::bit_store_to_flag_op, 5'h05, 3'h5, 1);
    `CSFX_CHECK(status_flag_register, 8'h4b)
    go(csfx_pkg::bit_load_from_flag_op, 5'h07, 3'h2, 1);
    chk(5'h07, 8'h04);
    `CSFX_CHECK(status_flag_register, 8'h4b)
    go(csfx_pkg::bit_store_to_flag_op, 5'h05, 3'h0, 1);
    `CSFX_CHECK(status_flag_register, fl)
    go(csfx_pkg::bit_load_from_flag_op, 5'h05, 3'h5, 1);
    chk(5'h05, 8'h00);
    done("shift and bits");
  endtask

  task automatic t_ptr();
    logic [4:0] lo;
    logic [7:0] v;
    for (int p = 0; p < 3; p++) begin
      lo = 5'h1a + 5'(2 * p);
      v = 8'h90 + 8'(p);
      setreg(lo, 8'h40);
      csfx_mem_model_i.mem[8'h40] = v;
      rq.ptr = csfx_pkg::csfx_ptr_t'(p);
      rq.amode = csfx_pkg::am_post_inc;
      go(csfx_pkg::indirect_load_op, 5'h01, 3'h0, 2);
      chk(5'h01, v);
      chk(lo, 8'h41);
      rq.amode = csfx_pkg::am_pre_dec;
      go(csfx_pkg::indirect_load_op, 5'h02, 3'h0, 2);
      chk(5'h02, v);
      chk(lo, 8'h40);
      go(csfx_pkg::indirect_store_op, 5'h10, 3'h0, 2);
      `CSFX_CHECK(csfx_mem_model_i.mem[8'h3f], 8'h00)
      chk(lo, 8'h3f);
      rq.amode = csfx_pkg::am_post_inc;
      go(csfx_pkg::indirect_store_op, 5'h01, 3'h0, 2);
      `CSFX_CHECK(csfx_mem_model_i.mem[8'h3f], v)
      chk(lo, 8'h40);
    end
    rq.amode = csfx_pkg::am_plain;
    for (int p = 1; p < 3; p++) begin
      lo = 5'h1a + 5'(2 * p);
      v = 8'ha0 + 8'(p);
      csfx_mem_model_i.mem[8'h45] = v;
      rq.ptr = csfx_pkg::csfx_ptr_t'(p);
      rq.disp = 6'h05;
      go(csfx_pkg::displaced_load_op, 5'h03, 3'h0, 2);
      chk(5'h03, v);
      chk(lo, 8'h40);
      go(csfx_pkg::indirect_load_op, 5'h04, 3'h0, 2);
      chk(5'h04, 8'h92);
      rq.disp = 6'h06;
      go(csfx_pkg::displaced_store_op, 5'h03, 3'h0, 2);
      `CSFX_CHECK(csfx_mem_model_i.mem[8'h46], v)
      chk(lo, 8'h40);
    end
    done("pointers");
  endtask

  task automatic t_direct_stack();
    rq.addr = 16'h0080;
    go(csfx_pkg::direct_data_store_op, 5'h03, 3'h0, 2);
    `CSFX_CHECK(csfx_mem_model_i.mem[8'h80], 8'ha2)
    go(csfx_pkg::stack_push_op, 5'h03, 3'h0, 2);
    `CSFX_CHECK(stack_ptr, 16'hffff)
    `CSFX_CHECK(csfx_mem_model_i.mem[8'h00], 8'ha2)
    go(csfx_pkg::stack_pop_op, 5'h0b, 3'h0, 2);
    chk(5'h0b, 8'ha2);
    `CSFX_CHECK(stack_ptr, 16'h0000)
    `CSFX_CHECK(status_flag_register, fl)
    done("direct and stack");
  endtask

  task automatic t_pgm_break();
    setreg(5'h1e, 8'h41);
    rq.pgm_to_r0 = 1'b1;
    go(csfx_pkg::program_memory_read_op, 5'h09, 3'h0, 3);
    chk(5'h00, 8'h85);
    chk(5'h09, 8'h00);
    rq.pgm_to_r0 = 1'b0;
    rq.amode = csfx_pkg::am_post_inc;
    go(csfx_pkg::program_memory_read_op, 5'h09, 3'h0, 3);
    chk(5'h09, 8'h85);
    chk(5'h1e, 8'h42);
    rq.amode = csfx_pkg::am_plain;
    go(csfx_pkg::program_memory_read_op, 5'h0a, 3'h0, 3);
    chk(5'h0a, 8'h21);
    rq.op = csfx_pkg::debug_break_op;
    @(posedge core_clk);
    #1;
    op_req = rq;
    op_valid = 1'b1;
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CSFX_CHECK(debug_halt, 1'b1)
    `CSFX_CHECK(status_flag_register, fl)
    debug_resume = 1'b1;
    @(posedge core_clk);
    #1;
    debug_resume = 1'b0;
    `CSFX_CHECK(debug_halt, 1'b0)
    done("program read and break");
  endtask

  task automatic final_report();
    $display("%0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far past the scenarios' length
  initial begin
    #40000;
    fail_count++;
    final_report();
  end

  initial begin
    fl = 8'h00;
    repeat (5) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_flags();
    t_shift_bits();
    t_ptr();
    t_direct_stack();
    t_pgm_break();
    final_report();
  end
endmodule // test_cpu_shift_flag_transfer_exec
